/* hw/rcic_fall_det.sv */
`timescale 1ns/1ps
module rcic_fall_det #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Level in, one-cycle falling-edge pulse out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] fall_o
);

    logic [W-1:0] prev;

    // Previous clears to low so a line that is low at reset gives no false edge.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            prev <= '0;
        else
            prev <= d_i;
    end

    assign fall_o = prev & ~d_i;

endmodule // rcic_fall_det

/* hw/rcic_pkg.sv */
package rcic_pkg;

    // Register byte addresses on the Wishbone slave.
    localparam logic [7:0] ADR_RESET_CAUSE = 8'h00;
    localparam logic [7:0] ADR_IRQ_STATUS  = 8'h04;
    localparam logic [7:0] ADR_IRQ_MASK    = 8'h08;
    localparam logic [7:0] ADR_PORT_CFG    = 8'h0C;
    localparam logic [7:0] ADR_PORT_DATA   = 8'h10;

    // Interrupt source positions in the status and mask registers.
    localparam int NUM_IRQ     = 3;
    localparam int IRQ_TIMER   = 0;
    localparam int IRQ_CHANGE  = 1;
    localparam int IRQ_EXT_PIN = 2;

    // Reset cause register fields.
    localparam int CAUSE_TIME_OUT   = 0;
    localparam int CAUSE_POWER_DOWN = 1;
    localparam int CAUSE_SLEEPING   = 2;
    localparam int CAUSE_MODE_LSB   = 3;

    // Port configuration register fields and reset value.
    localparam int          CFG_EXT_PIN  = 8;
    localparam int          CFG_WDT_EN   = 9;
    localparam int          CFG_OSC_TYPE = 10;
    localparam int          CFG_XFREQ    = 11;
    localparam int          CFG_W        = 12;
    localparam logic [11:0] CFG_RST      = 12'h2FF;

    // Reset values of the cause flags and the interrupt vectors.
    localparam logic        TIME_OUT_RST   = 1'b1;
    localparam logic        POWER_DOWN_RST = 1'b1;
    localparam logic [9:0]  VEC_HW         = 10'h008;
    localparam logic [9:0]  VEC_SW         = 10'h001;

    typedef enum logic [1:0] {MODE_EXT_RC, MODE_HIGH_XTAL, MODE_LOW_XTAL} rcic_clk_mode_e;
    typedef enum logic {PWR_RUN, PWR_SLEEP} rcic_pwr_e;

endpackage

/* hw/rcic_sync.sv */
`timescale 1ns/1ps
module rcic_sync #(
    parameter int         W       = 1,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Asynchronous input and synchronised output
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta;

    // Two flops; only the second stage is visible to any logic.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= RST_VAL[W-1:0];
            q_o  <= RST_VAL[W-1:0];
        end
        else
        begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule // rcic_sync

/* hw/rcic_top.sv */
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module rcic_top (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Wishbone slave
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [7:0]              adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic      [31:0]             dat_o,
    output logic                         ack_o,
    // Instruction sequencer strobes
    input  wire logic                    watchdog_clear_instr_i,
    input  wire logic                    sleep_instr_i,
    input  wire logic                    global_irq_on_instr_i,
    input  wire logic                    global_irq_off_instr_i,
    input  wire logic                    return_from_isr_instr_i,
    input  wire logic                    sw_irq_instr_i,
    // Event sources and pins
    input  wire logic                    watchdog_timeout_i,
    input  wire logic                    timer_counter_ovf_i,
    input  wire logic                    reset_pin_n_i,
    input  wire logic [7:0]              port6_i,
    // Core control
    output logic                         core_reset_o,
    output logic                         vector_o,
    output logic      [9:0]              vector_addr_o,
    output logic                         resume_o,
    output logic                         sleeping_o,
    output logic                         global_irq_en_o,
    output logic                         watchdog_timer_en_o,
    output rcic_pkg::rcic_clk_mode_e     clock_mode_o
);

    logic [rcic_pkg::NUM_IRQ-1:0] irq_flags;
    logic [rcic_pkg::NUM_IRQ-1:0] irq_mask;
    logic [rcic_pkg::CFG_W-1:0]   cfg;
    logic [7:0]                   chg_ref;
    logic                         time_out;
    logic                         power_down;
    logic                         gie;
    logic                         pin_prev;
    rcic_pkg::rcic_pwr_e          pwr;
    logic [7:0]                   port_s;
    logic                         pin_s;
    logic [1:0]                   falls;

    // Pins pass two flops; the reset pin idles high.
    rcic_sync #(.W(8), .RST_VAL(8'h00)) u_port_sync (.clk_i(clk_i), .rst_i(rst_i),
        .d_i(port6_i), .q_o(port_s));
    rcic_sync #(.W(1), .RST_VAL(8'h01)) u_pin_sync (.clk_i(clk_i), .rst_i(rst_i),
        .d_i(reset_pin_n_i), .q_o(pin_s));

    // Falling edges of the timer carry line and the synchronised external pin.
    rcic_fall_det #(.W(2)) u_fall (.clk_i(clk_i), .rst_i(rst_i),
        .d_i({port_s[0], timer_counter_ovf_i}), .fall_o(falls));

    // Bus decode; a request is accepted once, in the cycle before ack.
    wire        acc      = cyc_i && stb_i && !ack_o;
    wire        wr       = acc && we_i;
    wire        rd       = acc && !we_i;
    wire [31:0] lane     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [31:0] wdat     = dat_i & lane;
    wire        wr_stat  = wr && adr_i == rcic_pkg::ADR_IRQ_STATUS && sel_i[0];
    wire        wr_mask  = wr && adr_i == rcic_pkg::ADR_IRQ_MASK && sel_i[0];
    wire        wr_cfg   = wr && adr_i == rcic_pkg::ADR_PORT_CFG;
    wire        rd_port  = rd && adr_i == rcic_pkg::ADR_PORT_DATA;
    wire        running  = pwr == rcic_pkg::PWR_RUN;
    wire        sleeping = pwr == rcic_pkg::PWR_SLEEP;
    // Reset pin completes its pulse on the return to high.
    wire        pin_evt  = pin_s && !pin_prev;
    wire        core_evt = pin_evt || watchdog_timeout_i;
    // Change detection: inputs only, bit 0 dropped in external pin mode.
    wire [7:0]  ext_excl = {7'h00, cfg[rcic_pkg::CFG_EXT_PIN]};
    wire [7:0]  chg_bits = (port_s ^ chg_ref) & cfg[7:0] & ~ext_excl;
    wire        chg_hit  = (|chg_bits) && irq_mask[rcic_pkg::IRQ_CHANGE];
    wire        wake_chg = sleeping && chg_hit && !core_evt;
    wire        ext_fall = falls[1] && cfg[rcic_pkg::CFG_EXT_PIN];
    wire [2:0]  set_vec  = {ext_fall, chg_hit, falls[0]};
    // Vector requests; hardware wins over the software instruction.
    wire        pending  = |(irq_flags & irq_mask);
    wire        hw_vec   = running && gie && pending && !core_evt;
    wire        sw_vec   = running && gie && sw_irq_instr_i && !hw_vec && !core_evt;
    // Byte-lane merge for the wide config register.
    wire [11:0] cfg_wr   = (cfg & ~lane[11:0]) | wdat[11:0];
    wire [2:0]  stat_wr  = wdat[2:0];
    wire [2:0]  next_flags = (wr_stat ? stat_wr : irq_flags) | set_vec;
    // Clock mode decode from the oscillator type and frequency bits.
    wire        osc_xtal = cfg[rcic_pkg::CFG_OSC_TYPE];
    wire        xf_high  = cfg[rcic_pkg::CFG_XFREQ];
    rcic_pkg::rcic_clk_mode_e next_mode;
    assign next_mode = !osc_xtal ? rcic_pkg::MODE_EXT_RC :
                       (xf_high ? rcic_pkg::MODE_HIGH_XTAL : rcic_pkg::MODE_LOW_XTAL);

    // Read mux; the status register shows only unmasked requests.
    wire [31:0] rd_cause = {27'h0, clock_mode_o, sleeping, power_down, time_out};
    wire [31:0] rd_mux   =
        adr_i == rcic_pkg::ADR_RESET_CAUSE ? rd_cause :
        adr_i == rcic_pkg::ADR_IRQ_STATUS  ? {29'h0, irq_flags & irq_mask} :
        adr_i == rcic_pkg::ADR_IRQ_MASK    ? {29'h0, irq_mask} :
        adr_i == rcic_pkg::ADR_PORT_CFG    ? {20'h0, cfg} :
        adr_i == rcic_pkg::ADR_PORT_DATA   ? {24'h0, port_s} : 32'h0;

    // Bus answer one cycle after acceptance; unmapped reads give zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            ack_o <= acc;
            dat_o <= rd ? rd_mux : 32'h0;
        end
    end

    // Request flags and masks; a core reset clears both and beats a set, a set beats a status-write clear.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || core_evt)
        begin
            irq_flags <= '0;
            irq_mask  <= '0;
        end
        else
        begin
            irq_flags <= next_flags;
            if (wr_mask)
                irq_mask <= wdat[2:0];
        end
    end

    // Reading the port reloads the change reference.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            chg_ref <= 8'h00;
        else if (rd_port)
            chg_ref <= port_s;
    end

    // Config; a wake turns the watchdog back on over any write.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg <= rcic_pkg::CFG_RST;
        else
        begin
            if (wr_cfg)
                cfg <= cfg_wr;
            if (sleeping && (core_evt || wake_chg))
                cfg[rcic_pkg::CFG_WDT_EN] <= 1'b1;
        end
    end

    // Time-out and power-down flags by event, most severe first.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            time_out   <= rcic_pkg::TIME_OUT_RST;
            power_down <= rcic_pkg::POWER_DOWN_RST;
        end
        else if (pin_evt)
        begin
            if (sleeping)
            begin
                time_out   <= 1'b1;
                power_down <= 1'b0;
            end
        end
        else if (watchdog_timeout_i)
        begin
            time_out <= 1'b0;
            if (sleeping)
                power_down <= 1'b0;
        end
        else if (wake_chg)
        begin
            time_out   <= 1'b1;
            power_down <= 1'b0;
        end
        else if (sleep_instr_i && running)
        begin
            time_out   <= 1'b1;
            power_down <= 1'b0;
        end
        else if (watchdog_clear_instr_i)
        begin
            time_out   <= 1'b1;
            power_down <= 1'b1;
        end
    end

    // Power state: sleep until a reset source or an enabled change.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pwr <= rcic_pkg::PWR_RUN;
        else
        begin
            unique case (pwr)
                rcic_pkg::PWR_RUN:
                    if (sleep_instr_i && !core_evt)
                        pwr <= rcic_pkg::PWR_SLEEP;
                rcic_pkg::PWR_SLEEP:
                    if (core_evt || wake_chg)
                        pwr <= rcic_pkg::PWR_RUN;
            endcase
        end
    end

    // Global enable; taking a vector closes it until the return or enable-on instruction.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || core_evt)
            gie <= 1'b0;
        else if (hw_vec || sw_vec)
            gie <= 1'b0;
        else if (global_irq_on_instr_i || return_from_isr_instr_i)
            gie <= 1'b1;
        else if (global_irq_off_instr_i)
            gie <= 1'b0;
    end

    // Registered core outputs.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_reset_o        <= 1'b1;
            pin_prev            <= 1'b1;
            vector_o            <= 1'b0;
            vector_addr_o       <= rcic_pkg::VEC_HW;
            resume_o            <= 1'b0;
            sleeping_o          <= 1'b0;
            global_irq_en_o     <= 1'b0;
            watchdog_timer_en_o <= 1'b1;
            clock_mode_o        <= rcic_pkg::MODE_EXT_RC;
        end
        else
        begin
            core_reset_o        <= !pin_s || watchdog_timeout_i;
            pin_prev            <= pin_s;
            vector_o            <= hw_vec || sw_vec;
            if (hw_vec || sw_vec)
                vector_addr_o <= hw_vec ? rcic_pkg::VEC_HW : rcic_pkg::VEC_SW;
            resume_o            <= wake_chg && !gie;
            sleeping_o          <= sleeping;
            global_irq_en_o     <= gie;
            watchdog_timer_en_o <= cfg[rcic_pkg::CFG_WDT_EN];
            clock_mode_o        <= next_mode;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_quiet;
        !pin_evt && !watchdog_timeout_i && !wake_chg;
    endsequence
    property p_watchdog_clear_instr;
        s_quiet ##0 (watchdog_clear_instr_i && !(sleep_instr_i && running))
            |=> time_out && power_down;
    endproperty
    a_watchdog_clear_instr: assert property (p_watchdog_clear_instr) else $error("clear did not set both flags");
    property p_sleep;
        s_quiet ##0 (sleep_instr_i && running) |=> time_out && !power_down ##1 sleeping_o;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_wdt_run;
        watchdog_timeout_i && running && !pin_evt |=> !time_out && power_down == $past(power_down);
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset flags wrong");
    property p_pin_run;
        pin_evt && running |=> time_out == $past(time_out) && power_down == $past(power_down);
    endproperty
    a_pin_run: assert property (p_pin_run) else $error("pin reset changed flags");
    property p_pin_wake;
        pin_evt && sleeping |=> time_out && !power_down && running;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("pin wake flags wrong");
    property p_wdt_wake;
        watchdog_timeout_i && sleeping && !pin_evt |=> !time_out && !power_down && running;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake flags wrong");
    property p_chg_wake;
        wake_chg |=> time_out && !power_down ##1 watchdog_timer_en_o;
    endproperty
    a_chg_wake: assert property (p_chg_wake) else $error("change wake wrong");
    property p_hw_vec;
        hw_vec |=> vector_o && vector_addr_o == rcic_pkg::VEC_HW && !gie;
    endproperty
    a_hw_vec: assert property (p_hw_vec) else $error("hardware vector wrong");
    property p_sw_vec;
        sw_vec |=> vector_o && vector_addr_o == rcic_pkg::VEC_SW && !gie;
    endproperty
    a_sw_vec: assert property (p_sw_vec) else $error("software vector wrong");
    property p_return_from_isr_instr;
        return_from_isr_instr_i && !hw_vec && !sw_vec && !core_evt |=> gie ##1 global_irq_en_o;
    endproperty
    a_return_from_isr_instr: assert property (p_return_from_isr_instr) else $error("return did not enable");
    property p_stat_rd;
        rd && adr_i == rcic_pkg::ADR_IRQ_STATUS
            |=> ack_o && dat_o[2:0] == ($past(irq_flags) & $past(irq_mask));
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status read not masked");
    property p_rst_clear;
        core_evt |=> irq_mask == 3'h0 && irq_flags == 3'h0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset left irq state");

endmodule // rcic_top

/* test/rcic_seq_model.sv */
`timescale 1ns/1ps
module rcic_seq_model (
    // Clock
    input  wire logic       clk_i,
    // Instruction strobes and watchdog expiry, one-cycle pulses
    output logic [6:0]      strobe_o,
    // Level event sources and pins
    output logic            timer_ovf_o,
    output logic            reset_pin_n_o,
    output logic [7:0]      port_o
);
    // Idle core: no strobe, timer line low, reset pin and port pulled high.
    initial
    begin
        strobe_o      = 7'h00;
        timer_ovf_o   = 1'b0;
        reset_pin_n_o = 1'b1;
        port_o        = 8'hFF;
    end

    // The sequencer issues one instruction per cycle, so only one strobe is ever high.
    task automatic pulse(input int k);
        @(posedge clk_i);
        strobe_o[k] <= 1'b1;
        @(posedge clk_i);
        strobe_o[k] <= 1'b0;
    endtask

    // Levels move just after an edge, as the core's own registers would.
    task automatic set_lvl(input logic t, input logic p, input logic [7:0] d);
        @(posedge clk_i);
        timer_ovf_o   <= t;
        reset_pin_n_o <= p;
        port_o        <= d;
    endtask
endmodule // rcic_seq_model

/* test/tb_rcic_top.sv */
`timescale 1ns/1ps
module tb_rcic_top;
    localparam logic [7:0] A_CS = rcic_pkg::ADR_RESET_CAUSE;
    localparam logic [7:0] A_ST = rcic_pkg::ADR_IRQ_STATUS;
    localparam logic [7:0] A_MK = rcic_pkg::ADR_IRQ_MASK;
    localparam logic [7:0] A_CF = rcic_pkg::ADR_PORT_CFG;
    localparam logic [7:0] A_PD = rcic_pkg::ADR_PORT_DATA;
    localparam int WDC = 0, SLP = 1, ON = 2, OFF = 3, RET = 4, SWI = 5, WDT = 6;

    // Bench signals; every design input has a value at time zero.
    logic                     clk_i = 1'b0;
    logic                     rst_i = 1'b1;
    logic                     cyc_i = 1'b0;
    logic                     stb_i = 1'b0;
    logic                     we_i  = 1'b0;
    logic [7:0]               adr_i = 8'h00;
    logic [3:0]               sel_i = 4'h0;
    logic [31:0]              dat_i = 32'h0;
    logic [31:0]              dat_o;
    logic                     ack_o;
    logic [6:0]               strobe;
    logic                     timer_ovf;
    logic                     pin_n;
    logic [7:0]               port6;
    logic                     core_reset_o;
    logic                     vector_o;
    logic [9:0]               vector_addr_o;
    logic                     resume_o;
    logic                     sleeping_o;
    logic                     global_irq_en_o;
    logic                     watchdog_timer_en_o;
    rcic_pkg::rcic_clk_mode_e clock_mode_o;
    logic [31:0]              rd;
    logic [3:0]               c;
    logic [1:0]               em;
    int                       errors = 0;
    int                       tests_run = 0;

    // A 40 MHz clock.
    always #12.5 clk_i = ~clk_i;

    rcic_seq_model rcic_seq_model_i (.clk_i(clk_i), .strobe_o(strobe), .timer_ovf_o(timer_ovf),
        .reset_pin_n_o(pin_n), .port_o(port6));

    rcic_top rcic_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .watchdog_clear_instr_i(strobe[WDC]), .sleep_instr_i(strobe[SLP]),
        .global_irq_on_instr_i(strobe[ON]), .global_irq_off_instr_i(strobe[OFF]),
        .return_from_isr_instr_i(strobe[RET]), .sw_irq_instr_i(strobe[SWI]),
        .watchdog_timeout_i(strobe[WDT]), .timer_counter_ovf_i(timer_ovf),
        .reset_pin_n_i(pin_n), .port6_i(port6), .core_reset_o(core_reset_o),
        .vector_o(vector_o), .vector_addr_o(vector_addr_o), .resume_o(resume_o),
        .sleeping_o(sleeping_o), .global_irq_en_o(global_irq_en_o),
        .watchdog_timer_en_o(watchdog_timer_en_o), .clock_mode_o(clock_mode_o));

    // Verdict and the single place where the run ends.
    task automatic end_of_test();
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Word comparison; case inequality, so an unknown never matches.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask

    // Classic cycle: request held until ack is sampled, then released for a cycle.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_i);
            if (ack_o === 1'b1)
                break;
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n == 20)
        begin
            chk_bit("wb_ack", 1'b1, ack_o);
            end_of_test();
        end
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask

    // Watches vector (0), resume (1) or core reset (2) in a bounded window.
    task automatic wait_for(input int k, input logic want, input string n);
        logic seen;
        seen = 1'b0;
        repeat (12)
        begin
            #1;
            seen = (k == 0) ? vector_o === 1'b1 : (k == 1) ? resume_o === 1'b1 :
                   core_reset_o === 1'b1;
            if (seen)
                break;
            @(posedge clk_i);
        end
        chk_bit(n, want, seen);
        if (want && !seen)
            end_of_test();
    endtask

    // Main sequence: reset, then one scenario after another.
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd_chk("cause_por", A_CS, 32'h3);
        rd_chk("mask_por", A_MK, 32'h0);
        rd_chk("status_por", A_ST, 32'h0);
        rd_chk("unmapped", 8'h20, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            c = (i == 0) ? 4'h2 : (i == 1) ? 4'h6 : (i == 2) ? 4'hE : 4'hA;
            em = !c[2] ? 2'd0 : (c[3] ? 2'd1 : 2'd2);
            wb(1'b1, A_CF, {20'h0, c, 8'hFF});
            repeat (2) @(posedge clk_i);
            chk("clock_mode", {30'h0, em}, {30'h0, clock_mode_o});
        end
        rcic_seq_model_i.pulse(WDT);
        wait_for(2, 1'b1, "core_reset_wdt");
        rd_chk("cause_wdt_run", A_CS, 32'h2);
        rcic_seq_model_i.set_lvl(1'b0, 1'b0, 8'hFF);
        wait_for(2, 1'b1, "core_reset_pin");
        rcic_seq_model_i.set_lvl(1'b0, 1'b1, 8'hFF);
        repeat (8) @(posedge clk_i);
        chk_bit("core_reset_rel", 1'b0, core_reset_o);
        rd_chk("cause_pin_run", A_CS, 32'h2);
        rcic_seq_model_i.pulse(WDC);
        rd_chk("cause_wdc", A_CS, 32'h3);
        rcic_seq_model_i.pulse(SLP);
        rd_chk("cause_sleep", A_CS, 32'h5);
        chk_bit("sleeping", 1'b1, sleeping_o);
        rcic_seq_model_i.set_lvl(1'b0, 1'b0, 8'hFF);
        repeat (6) @(posedge clk_i);
        rcic_seq_model_i.set_lvl(1'b0, 1'b1, 8'hFF);
        repeat (8) @(posedge clk_i);
        rd_chk("cause_pin_wake", A_CS, 32'h1);
        rcic_seq_model_i.pulse(SLP);
        rcic_seq_model_i.pulse(WDT);
        wait_for(2, 1'b1, "core_reset_wdt_wake");
        rd_chk("cause_wdt_wake", A_CS, 32'h0);
        // Change wake: watchdog off and port read before arming the mask.
        wb(1'b1, A_CF, 32'h0FF);
        wb(1'b0, A_PD, 32'h0);
        wb(1'b1, A_MK, 32'h2);
        rcic_seq_model_i.pulse(SLP);
        rcic_seq_model_i.set_lvl(1'b0, 1'b1, 8'hDF);
        wait_for(1, 1'b1, "resume_change");
        rd_chk("cause_change_wake", A_CS, 32'h1);
        chk_bit("wdt_reenabled", 1'b1, watchdog_timer_en_o);
        rd_chk("status_change", A_ST, 32'h2);
        wb(1'b0, A_PD, 32'h0);
        wb(1'b1, A_ST, 32'h0);
        rd_chk("status_clear", A_ST, 32'h0);
        // Output pin and external-interrupt pin must not raise a change request.
        wb(1'b1, A_CF, 32'h1F7);
        wb(1'b0, A_PD, 32'h0);
        rcic_seq_model_i.set_lvl(1'b0, 1'b1, 8'hD6);
        repeat (6) @(posedge clk_i);
        rd_chk("status_excluded", A_ST, 32'h0);
        wb(1'b1, A_MK, 32'h6);
        rd_chk("status_ext_unmasked", A_ST, 32'h4);
        wait_for(0, 1'b0, "no_vector_gie_off");
        wb(1'b1, A_ST, 32'h0);
        wb(1'b1, A_MK, 32'h1);
        rcic_seq_model_i.pulse(ON);
        repeat (2) @(posedge clk_i);
        chk_bit("gie_on", 1'b1, global_irq_en_o);
        rcic_seq_model_i.set_lvl(1'b1, 1'b1, 8'hD6);
        rcic_seq_model_i.set_lvl(1'b0, 1'b1, 8'hD6);
        wait_for(0, 1'b1, "vector_timer");
        chk("vector_addr_hw", 32'h008, {22'h0, vector_addr_o});
        repeat (2) @(posedge clk_i);
        chk_bit("gie_vector", 1'b0, global_irq_en_o);
        rd_chk("status_timer", A_ST, 32'h1);
        wb(1'b1, A_ST, 32'h0);
        rcic_seq_model_i.pulse(RET);
        repeat (2) @(posedge clk_i);
        chk_bit("gie_return", 1'b1, global_irq_en_o);
        wait_for(0, 1'b0, "no_revector");
        rcic_seq_model_i.pulse(SWI);
        wait_for(0, 1'b1, "vector_sw");
        chk("vector_addr_sw", 32'h001, {22'h0, vector_addr_o});
        rcic_seq_model_i.pulse(OFF);
        rcic_seq_model_i.pulse(SWI);
        wait_for(0, 1'b0, "sw_disabled");
        // Watchdog reset clears the masks and the request flags.
        wb(1'b1, A_MK, 32'h7);
        rcic_seq_model_i.pulse(WDT);
        wait_for(2, 1'b1, "core_reset_final");
        rd_chk("mask_wdt", A_MK, 32'h0);
        rd_chk("status_wdt", A_ST, 32'h0);
        end_of_test();
    end
endmodule // tb_rcic_top
